// [bdsmc_pkg.sv]
// constants, types and state layout for the bridge driver spi and mode control block
// assumes a single 100 MHz clock; all pins arrive asynchronous to it
package bdsmc_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam real CLK_PERIOD_NS = 10.0;
  localparam real T_PO_MIN_US = 1.0;
  localparam real T_PO_MAX_US = 2.0;
  localparam real T_PD_MIN_US = 8.0;
  localparam real T_PD_MAX_US = 11.0;
  localparam real T_TURN_ON_MS = 1.0;
  localparam real T_XFER_GAP_NS = 300.0;
  localparam int PO_MIN_CYC = int'($ceil(T_PO_MIN_US * 1000.0 / CLK_PERIOD_NS));
  localparam int PO_MAX_CYC = int'($floor(T_PO_MAX_US * 1000.0 / CLK_PERIOD_NS));
  localparam int PD_MIN_CYC = int'($ceil(T_PD_MIN_US * 1000.0 / CLK_PERIOD_NS));
  localparam int PD_MAX_CYC = int'($floor(T_PD_MAX_US * 1000.0 / CLK_PERIOD_NS));
  localparam int TURN_ON_CYC = int'($floor(T_TURN_ON_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int CNT_W = 17;

  // ****************************************************************
  // spi word layout
  // ****************************************************************
  localparam int WORD_W = 16;
  localparam int CMD_WR_BIT = 15;
  localparam int ADDR_HI = 14;
  localparam int ADDR_LO = 13;
  localparam logic [1:0] ADDR_ID = 2'h0;
  localparam logic [1:0] ADDR_STATUS = 2'h1;
  localparam logic [1:0] ADDR_MASK = 2'h2;
  localparam logic [1:0] ADDR_CFG = 2'h3;

  // ****************************************************************
  // status, mask and config fields
  // ****************************************************************
  localparam int FAULT_W = 11;
  localparam int FLT_TW = 1;
  localparam int FLT_OC = 2;
  localparam int FLT_OV = 8;
  localparam int MASK_DOV = 12;
  localparam int CFG_W = 13;
  localparam int CFG_VIN_A = 0;
  localparam int CFG_VIN_B = 1;
  localparam int CFG_INPUT = 2;
  localparam int CFG_FULL = 3;
  localparam int CFG_EN = 4;
  localparam int CFG_SR_LO = 5;
  localparam int CFG_ILM_LO = 8;
  localparam logic [CFG_W-1:0] CFG_RST = 13'h0d98;
  localparam logic [CFG_W-1:0] MASK_RST = 13'h06f1;
  // faults that force the outputs off regardless of the mask
  localparam logic [FAULT_W-1:0] SHUTDOWN_FAULTS = 11'h6f5;

  // ****************************************************************
  // pin sampling: 0 sclk, 1 select_n, 2 mosi, 3 wake, 4 kill, 5 drive a, 6 drive b
  // ****************************************************************
  localparam int PIN_W = 7;
  localparam logic [PIN_W-1:0] PIN_RST = 7'h02;

  typedef enum logic [5:0] {
    MODE_SLEEP = 6'h01,
    MODE_POWERUP = 6'h02,
    MODE_STANDBY = 6'h04,
    MODE_NORMAL = 6'h08,
    MODE_FAULT = 6'h10,
    MODE_POWERDOWN = 6'h20
  } bdsmc_mode_t;

  typedef struct packed {
    logic [PIN_W-1:0] pin_s1;
    logic [PIN_W-1:0] pin_s2;
    logic [PIN_W-1:0] pin_s3;
    logic [PIN_W-1:0] pin_f;
    logic [WORD_W-1:0] sh;
    logic [3:0] bit_cnt;
    logic any_clk;
    logic miso;
    logic miso_oe;
    logic [1:0] sel;
    logic [FAULT_W-1:0] faults;
    logic framing_error_bit;
    logic [CFG_W-1:0] mask;
    logic [CFG_W-1:0] cfg;
    logic pend_valid;
    logic [WORD_W-1:0] pend_data;
    bdsmc_mode_t st;
    logic [CNT_W-1:0] cnt;
    logic leg_a;
    logic leg_b;
    logic leg_oe;
    logic flag_n;
    logic supplies_on;
  } bdsmc_state_t;

endpackage : bdsmc_pkg

// [bdsmc_spi_master.sv]
// host model: spi master for the bridge driver bench
// assumes the bench clock at 100 MHz; sclk idles low, 160 ns period
module bdsmc_spi_master (
  input wire logic i_clk,
  input wire logic i_miso,
  input wire logic i_miso_oe,
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_mosi
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // frame driver
  // ************************************************************
  // idle lines; mosi is driven low so it rests low
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end
  // idle gap kept at 400 ns, above the minimum
  // entered on a clock edge; a released miso reads as z so it never matches
  task automatic xfer(input logic [31:0] d, input int n, output logic [31:0] r);
    r = '0;
    o_cs_n <= 1'b0;
    repeat (8) @(posedge i_clk);
    for (int k = n - 1; k >= 0; k--) begin
      o_sclk <= 1'b1;
      o_mosi <= d[k];
      repeat (8) @(posedge i_clk);
      r[k] = (i_miso_oe === 1'b1) ? i_miso : 1'bz;
      o_sclk <= 1'b0;
      repeat (8) @(posedge i_clk);
    end
    o_cs_n <= 1'b1;
    o_mosi <= 1'b0;
    repeat (40) @(posedge i_clk);
  endtask : xfer
endmodule : bdsmc_spi_master

// [bdsmc_top.sv]
// spi slave, register set and mode sequencer of the bridge driver, plus its command fifo
// assumes all pins are asynchronous to i_clk and sclk stays well below a quarter of i_clk

// ****************************************************************
// command fifo
// ****************************************************************
module bdsmc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0] wr;
    logic [PTR_W-1:0] rd;
    logic [CNT_W-1:0] cnt;
    logic out_valid;
    logic [WIDTH-1:0] out_data;
  } bdsmc_fifo_state_t;

  bdsmc_fifo_state_t f_reg;
  bdsmc_fifo_state_t f_next;
  logic push;
  logic pull;

  // output stage keeps the read port straight from a flop
  always_comb begin
    f_next = f_reg;
    push = i_in_valid && (f_reg.cnt != CNT_W'(DEPTH));
    pull = (f_reg.cnt != '0) && (!f_reg.out_valid || i_out_ready);
    if (f_reg.out_valid && i_out_ready) begin
      f_next.out_valid = 1'b0;
    end
    if (pull) begin
      f_next.out_data = f_reg.mem[f_reg.rd];
      f_next.out_valid = 1'b1;
      f_next.rd = (f_reg.rd == PTR_W'(DEPTH - 1)) ? '0 : f_reg.rd + PTR_W'(1);
    end
    if (push) begin
      f_next.mem[f_reg.wr] = i_in_data;
      f_next.wr = (f_reg.wr == PTR_W'(DEPTH - 1)) ? '0 : f_reg.wr + PTR_W'(1);
    end
    if (push && !pull) begin
      f_next.cnt = f_reg.cnt + CNT_W'(1);
    end else if (pull && !push) begin
      f_next.cnt = f_reg.cnt - CNT_W'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      f_reg <= '0;
    end else begin
      f_reg <= f_next;
    end
  end

  assign o_in_ready = (f_reg.cnt != CNT_W'(DEPTH));
  assign o_out_valid = f_reg.out_valid;
  assign o_out_data = f_reg.out_data;

endmodule : bdsmc_fifo

// ****************************************************************
// top level
// ****************************************************************
module bdsmc_top import bdsmc_pkg::*; #(
  parameter int P_TURN_ON_CYC = TURN_ON_CYC,
  parameter logic [4:0] P_ID_BITS = 5'h00, // identity value is arbitrary
  parameter int P_FIFO_DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_mosi,
  output logic o_miso,
  output logic o_miso_oe,
  input wire logic i_wake_pin,
  input wire logic i_output_kill_pin,
  input wire logic i_drive_input_a,
  input wire logic i_drive_input_b,
  input wire logic i_battery_ok,
  input wire logic i_cp_ok,
  input wire logic i_supplies_ready,
  input wire logic [FAULT_W-1:0] i_fault_raw,
  output logic o_fault_flag_n,
  output logic o_bridge_leg_a,
  output logic o_bridge_leg_b,
  output logic o_bridge_leg_oe,
  output logic [2:0] o_slew_rate,
  output logic [1:0] o_current_limit,
  output logic o_full_bridge,
  output logic o_supplies_on,
  output logic o_cmd_valid,
  output logic [WORD_W-1:0] o_cmd_data,
  input wire logic i_cmd_ready
);

  bdsmc_state_t r_reg;
  bdsmc_state_t r_next;
  logic [PIN_W-1:0] rise;
  logic [PIN_W-1:0] fall;
  logic cs_low;
  logic frame_end;
  logic frame_ok;
  logic accept;
  logic fifo_ready;
  logic is_write;
  logic [1:0] addr;
  logic frm_set;
  logic frm_clr;
  logic [FAULT_W-1:0] flt_clr;
  logic masked_fault;
  logic shutdown;
  logic kill;
  logic [WORD_W-1:0] resp;

  always_comb begin
    r_next = r_reg;
    // ****************************************************************
    // pin sampling: a change counts once stages two and three agree
    // ****************************************************************
    r_next.pin_s1 = {i_drive_input_b, i_drive_input_a, i_output_kill_pin, i_wake_pin,
                     i_mosi, i_cs_n, i_sclk};
    r_next.pin_s2 = r_reg.pin_s1;
    r_next.pin_s3 = r_reg.pin_s2;
    r_next.pin_f = (r_reg.pin_s2 & ~(r_reg.pin_s2 ^ r_reg.pin_s3))
                 | (r_reg.pin_f & (r_reg.pin_s2 ^ r_reg.pin_s3));
    rise = r_next.pin_f & ~r_reg.pin_f;
    fall = ~r_next.pin_f & r_reg.pin_f;
    cs_low = !r_next.pin_f[1];
    kill = r_next.pin_f[4];

    // word for the register chosen last time
    unique case (r_reg.sel)
      ADDR_ID: resp = {11'h000, P_ID_BITS};
      ADDR_STATUS: resp = {4'h0, r_reg.framing_error_bit, r_reg.faults};
      ADDR_MASK: resp = {3'h0, r_reg.mask};
      ADDR_CFG: resp = {3'h0, r_reg.cfg};
    endcase

    // ****************************************************************
    // spi shifter
    // ****************************************************************
    // fixed slave mode and word
    frame_end = rise[1];
    frame_ok = frame_end && r_reg.any_clk && (r_reg.bit_cnt == 4'h0);
    if (!cs_low) begin
      r_next.bit_cnt = 4'h0;
      r_next.any_clk = 1'b0;
      r_next.sh = '0;
      r_next.miso_oe = 1'b0;
    end else if (fall[1]) begin
      // load the answer as select falls
      r_next.sh = resp;
      r_next.miso = resp[WORD_W-1];
      r_next.miso_oe = 1'b1;
    end else begin
      if (fall[0]) begin
        r_next.sh = {r_reg.sh[WORD_W-2:0], r_next.pin_f[2]};
        r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
        r_next.any_clk = 1'b1;
      end
      // after sixteen, received bits flow on out
      if (rise[0]) begin
        r_next.miso = r_reg.sh[WORD_W-1];
      end
    end

    // ****************************************************************
    // command decode: one word applied as the fifo takes it
    // ****************************************************************
    accept = r_reg.pend_valid && fifo_ready;
    is_write = r_reg.pend_data[CMD_WR_BIT];
    addr = r_reg.pend_data[ADDR_HI:ADDR_LO];
    frm_set = frame_end && !frame_ok;
    frm_clr = 1'b0;
    flt_clr = '0;
    if (accept) begin
      r_next.pend_valid = 1'b0;
      r_next.sel = addr;
      if (is_write) begin
        unique case (addr)
          // write to zero is a framing error
          ADDR_ID: frm_set = 1'b1;
          ADDR_STATUS: begin
            // clear only faults no longer present
            flt_clr = r_reg.pend_data[FAULT_W-1:0] & ~i_fault_raw;
            frm_clr = r_reg.pend_data[FAULT_W];
          end
          ADDR_MASK: r_next.mask = r_reg.pend_data[CFG_W-1:0];
          ADDR_CFG: r_next.cfg = r_reg.pend_data[CFG_W-1:0];
        endcase
      end
    end
    // a finished word waits for fifo room; a second one meanwhile is lost
    if (frame_ok) begin
      if (!r_reg.pend_valid || accept) begin
        r_next.pend_valid = 1'b1;
        r_next.pend_data = r_reg.sh;
      end else begin
        frm_set = 1'b1;
      end
    end
    if (rise[3]) begin
      r_next.sel = ADDR_STATUS;
    end
    // wake rise and kill fall also drop faults that have gone
    if (rise[3] || fall[4]) begin
      flt_clr = ~i_fault_raw;
      frm_clr = 1'b1;
    end
    // faults latch; a new event beats a clear
    r_next.faults = (r_reg.faults & ~flt_clr) | i_fault_raw;
    r_next.framing_error_bit = (r_reg.framing_error_bit & ~frm_clr) | frm_set;

    // ****************************************************************
    // mode sequencer
    // ****************************************************************
    masked_fault = (({r_reg.framing_error_bit, r_reg.faults} & r_reg.mask[FAULT_W:0]) != '0);
    shutdown = ((r_reg.faults & SHUTDOWN_FAULTS) != '0) || (i_fault_raw[FLT_OC]);
    r_next.cnt = r_reg.cnt + CNT_W'(1);
    unique case (r_reg.st)
      MODE_SLEEP: begin
        if (rise[3] && i_battery_ok) begin
          r_next.st = MODE_POWERUP;
          r_next.cnt = '0;
        end
      end
      MODE_POWERUP: begin
        // hold flag for the minimum, then wait for pump
        if ((r_reg.cnt >= CNT_W'(PO_MIN_CYC - 1)) && i_cp_ok && i_supplies_ready) begin
          r_next.st = MODE_STANDBY;
        end else if (r_reg.cnt >= CNT_W'(P_TURN_ON_CYC - 1)) begin
          // supplies late: report in fault mode, supplies kept on, back to standby once no fault remains
          r_next.st = MODE_FAULT;
        end
      end
      MODE_STANDBY: begin
        // enable bit and kill pin gate the legs
        if (r_reg.cfg[CFG_EN] && !kill && !shutdown && !masked_fault) begin
          r_next.st = MODE_NORMAL;
        end
      end
      MODE_NORMAL: begin
        if (shutdown || masked_fault) begin
          r_next.st = MODE_FAULT;
        end else if (kill || !r_reg.cfg[CFG_EN]) begin
          r_next.st = MODE_STANDBY;
        end
      end
      MODE_FAULT: begin
        if (!shutdown && !masked_fault && !(r_reg.cnt < CNT_W'(PO_MIN_CYC))) begin
          r_next.st = MODE_STANDBY;
        end
      end
      MODE_POWERDOWN: begin
        // supplies drop after the turn-off delay
        if (r_reg.cnt >= CNT_W'(PD_MIN_CYC - 1)) begin
          r_next.st = MODE_SLEEP;
        end
      end
      default: r_next.st = MODE_SLEEP;
    endcase
    if (r_next.st != r_reg.st) begin
      r_next.cnt = '0;
    end
    if (!r_next.pin_f[3] && (r_reg.st != MODE_SLEEP) && (r_reg.st != MODE_POWERDOWN)) begin
      r_next.st = MODE_POWERDOWN;
      r_next.cnt = '0;
    end

    // ****************************************************************
    // outputs, all registered
    // ****************************************************************
    // sleep all off, standby legs released
    r_next.supplies_on = (r_next.st != MODE_SLEEP);
    // released in sleep, otherwise only in standby or normal with kill low and no masked fault
    r_next.flag_n = (r_next.st == MODE_SLEEP)
                  || (((r_next.st == MODE_STANDBY) || (r_next.st == MODE_NORMAL))
                      && !kill && !masked_fault);
    // drive only in normal, off at once on overcurrent
    r_next.leg_oe = (r_next.st == MODE_NORMAL) && !i_fault_raw[FLT_OC] && r_next.pin_f[3];
    r_next.leg_a = r_reg.cfg[CFG_INPUT] ? r_reg.cfg[CFG_VIN_A] : r_next.pin_f[5];
    r_next.leg_b = r_reg.cfg[CFG_INPUT] ? r_reg.cfg[CFG_VIN_B] : r_next.pin_f[6];
    // overvoltage in full bridge brakes through both high sides
    if (r_reg.cfg[CFG_FULL] && !r_reg.mask[MASK_DOV] && i_fault_raw[FLT_OV]) begin
      r_next.leg_a = 1'b1;
      r_next.leg_b = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      r_reg <= '0;
      r_reg.pin_s1 <= PIN_RST;
      r_reg.pin_s2 <= PIN_RST;
      r_reg.pin_s3 <= PIN_RST;
      r_reg.pin_f <= PIN_RST;
      r_reg.sel <= ADDR_STATUS;
      r_reg.mask <= MASK_RST;
      r_reg.cfg <= CFG_RST;
      r_reg.st <= MODE_SLEEP;
      r_reg.flag_n <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // accepted commands stream out for the system to log
  bdsmc_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(P_FIFO_DEPTH)
  ) u_cmd_fifo (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_in_valid(r_reg.pend_valid),
    .o_in_ready(fifo_ready),
    .i_in_data(r_reg.pend_data),
    .o_out_valid(o_cmd_valid),
    .o_out_data(o_cmd_data),
    .i_out_ready(i_cmd_ready)
  );

  assign o_miso = r_reg.miso;
  assign o_miso_oe = r_reg.miso_oe;
  assign o_fault_flag_n = r_reg.flag_n;
  assign o_bridge_leg_a = r_reg.leg_a;
  assign o_bridge_leg_b = r_reg.leg_b;
  assign o_bridge_leg_oe = r_reg.leg_oe;
  assign o_slew_rate = r_reg.cfg[CFG_SR_LO+2:CFG_SR_LO];
  assign o_current_limit = r_reg.cfg[CFG_ILM_LO+1:CFG_ILM_LO];
  assign o_full_bridge = r_reg.cfg[CFG_FULL];
  assign o_supplies_on = r_reg.supplies_on;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_bad_frame_frm: assert property (
    frame_end && !frame_ok |=> r_reg.framing_error_bit) else $error("framing error not recorded");
  a_read_no_change: assert property (
    accept && !is_write |=> $stable(r_reg.cfg) && $stable(r_reg.mask)
      && (r_reg.sel == $past(addr))) else $error("read altered a register");
  a_write_zero_frm: assert property (
    accept && is_write && (addr == ADDR_ID) |=> r_reg.framing_error_bit) else $error("write to zero missed");
  a_miso_release: assert property (
    rise[1] |=> !o_miso_oe) else $error("miso still driven after select rise");
  a_wake_low_off: assert property (
    $fell(r_reg.pin_f[3]) && (r_reg.st != MODE_SLEEP) |-> ##0 1'b1 ##1
      (!o_bridge_leg_oe && !o_fault_flag_n)) else $error("wake fall did not stop legs");
  a_pd_flag_low: assert property (
    (r_reg.st == MODE_POWERDOWN) |-> !o_fault_flag_n && o_supplies_on)
    else $error("flag released during power down");
  a_pd_delay_min: assert property (
    $fell(o_supplies_on) |-> $past(r_reg.cnt) >= CNT_W'(PD_MIN_CYC - 1))
    else $error("power down earlier than delay");
  a_po_min_low: assert property (
    $rose(o_fault_flag_n) && $past(r_reg.st == MODE_POWERUP)
      |-> $past(r_reg.cnt) >= CNT_W'(PO_MIN_CYC - 1)) else $error("power up pulse too short");
  a_kill_holds_flag: assert property (
    o_fault_flag_n && o_supplies_on |-> !r_reg.pin_f[4]) else $error("flag up with kill high");
  a_status_first: assert property (
    rise[3] |=> (r_reg.sel == ADDR_STATUS)) else $error("status not selected after wake");
  a_oc_shutdown: assert property (
    i_fault_raw[FLT_OC] |=> !o_bridge_leg_oe ##1 r_reg.faults[FLT_OC])
    else $error("overcurrent did not stop legs");
  a_fault_mode: assert property (
    (r_reg.st == MODE_NORMAL) && shutdown && r_reg.pin_f[3] |=> (r_reg.st == MODE_FAULT))
    else $error("normal mode kept with fault");

  c_good_frame: cover property (frame_ok ##[1:50] accept);
  c_write_cfg: cover property (accept && is_write && (addr == ADDR_CFG));
  c_run_normal: cover property ((r_reg.st == MODE_STANDBY) ##1 (r_reg.st == MODE_NORMAL));
  c_power_down: cover property ($fell(o_supplies_on));

endmodule : bdsmc_top

// [bdsmc_top_test.sv]
// self-checking bench for the bridge driver spi and mode control block
// assumes bdsmc_spi_master as host and a shortened turn-on timeout
module bdsmc_top_test import bdsmc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, wake = 1'b0, kill = 1'b0, ready = 1'b1, drv_a = 1'b0;
  logic drv_b = 1'b0;
  logic [FAULT_W-1:0] raw = '0;
  logic sclk, cs_n, mosi, miso, miso_oe, flag_n, leg_a, leg_b, leg_oe, full, sup_on, cvalid;
  logic [2:0] slew;
  logic [1:0] lim;
  logic [WORD_W-1:0] cdata, last;
  logic [31:0] r;
  int fails = 0, checked = 0, pops = 0, lo, p0;
  // command in the upper half, expected answer in the lower
  logic [31:0] rows [9] = '{32'h4000_0000, 32'h6000_06f1, 32'he2b7_0d98, 32'h7fff_02b7,
    32'h2000_02b7, 32'h8000_0000, 32'h2000_0000, 32'ha800_0800, 32'h2000_0000};
  always #5 clk = ~clk;
  bdsmc_spi_master i_bdsmc_spi_master (.i_clk(clk), .i_miso(miso), .i_miso_oe(miso_oe),
    .o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi));
  bdsmc_top #(.P_TURN_ON_CYC(300)) i_bdsmc_top (.i_clk(clk), .i_rst(rst), .i_sclk(sclk),
    .i_cs_n(cs_n), .i_mosi(mosi), .o_miso(miso), .o_miso_oe(miso_oe), .i_wake_pin(wake),
    .i_output_kill_pin(kill), .i_drive_input_a(drv_a), .i_drive_input_b(drv_b),
    .i_battery_ok(1'b1), .i_cp_ok(1'b1), .i_supplies_ready(1'b1), .i_fault_raw(raw),
    .o_fault_flag_n(flag_n), .o_bridge_leg_a(leg_a), .o_bridge_leg_b(leg_b),
    .o_bridge_leg_oe(leg_oe), .o_slew_rate(slew), .o_current_limit(lim),
    .o_full_bridge(full), .o_supplies_on(sup_on), .o_cmd_valid(cvalid),
    .o_cmd_data(cdata), .i_cmd_ready(ready));
  // sink side of the command fifo
  always @(posedge clk) if (cvalid === 1'b1 && ready) begin
    pops <= pops + 1;
    last <= cdata;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic close_out();
    if (fails == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  // watchdog, about six times the expected run
  initial begin
    #500us;
    fails++;
    close_out();
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("sleep flag", 1, flag_n);
    wake <= 1'b1;
    for (int k = 0; k < 20 && flag_n !== 1'b0; k++) @(posedge clk);
    lo = 0;
    while (flag_n === 1'b0 && lo < 400) begin
      @(posedge clk);
      lo++;
    end
    chk("powerup width", 1, lo >= PO_MIN_CYC && lo <= PO_MAX_CYC);
    chk("awake", 2'b11, {sup_on, flag_n});
    foreach (rows[k]) begin
      i_bdsmc_spi_master.xfer({16'h0, rows[k][31:16]}, 16, r);
      chk("answer", {16'h0, rows[k][15:0]}, r);
    end
    repeat (10) @(posedge clk);
    chk("cfg outputs", 9'h1ec, {leg_oe, leg_a, leg_b, slew, lim, full});
    kill <= 1'b1;
    repeat (10) @(posedge clk);
    chk("kill flag", 0, flag_n);
    kill <= 1'b0;
    repeat (10) @(posedge clk);
    chk("kill released", 1, flag_n);
    // short frame, then a chained double frame
    i_bdsmc_spi_master.xfer(32'h0, 8, r);
    i_bdsmc_spi_master.xfer(32'h4321_2000, 32, r);
    chk("chain", 32'h0800_4321, r);
    chk("miso released", 0, miso_oe);
    // stall the sink: eight in the queue, one at its output, one waits, the eleventh is lost
    ready <= 1'b0;
    p0 = pops;
    repeat (11) i_bdsmc_spi_master.xfer(32'h2000, 16, r);
    chk("stalled", p0, pops);
    ready <= 1'b1;
    repeat (30) @(posedge clk);
    chk("drained", p0 + 10, pops);
    chk("fifo word", 16'h2000, last);
    raw <= 11'h006;
    repeat (6) @(posedge clk);
    chk("overcurrent", 2'b00, {leg_oe, flag_n});
    raw <= '0;
    i_bdsmc_spi_master.xfer(32'h2000, 16, r);
    chk("status", 16'h0806, r);
    // clear the latched faults so normal running resumes, then steer legs from the pins
    drv_a <= 1'b1;
    i_bdsmc_spi_master.xfer(32'ha807, 16, r);
    chk("status again", 16'h0806, r);
    chk("recovered", 2'b11, {leg_oe, flag_n});
    i_bdsmc_spi_master.xfer(32'he2bb, 16, r);
    chk("pin legs", 4'b1101, {leg_oe, leg_a, leg_b, full});
    drv_a <= 1'b0;
    drv_b <= 1'b1;
    repeat (10) @(posedge clk);
    chk("pin legs swap", 3'b101, {leg_oe, leg_a, leg_b});
    // overvoltage in full bridge brakes through both high sides
    raw <= 11'h100;
    repeat (6) @(posedge clk);
    chk("ov brake", 3'b111, {leg_oe, leg_a, leg_b});
    raw <= '0;
    wake <= 1'b0;
    repeat (8) @(posedge clk);
    chk("wake low", 2'b00, {leg_oe, flag_n});
    repeat (PD_MIN_CYC - 20) @(posedge clk);
    chk("powerdown hold", 2'b10, {sup_on, flag_n});
    for (int k = 0; k < 400 && flag_n !== 1'b1; k++) @(posedge clk);
    chk("asleep", 2'b01, {sup_on, flag_n});
    close_out();
  end
endmodule : bdsmc_top_test
